// ==== core/apdm_host.sv ====
`timescale 1ns/1ps
`default_nettype none
module apdm_host (
  input wire logic clk,
  input wire logic rstn,
  apdm_if.host link,
  input wire logic cmd_valid,
  input wire apdm_pkg::apdm_cmd_e cmd,
  output logic cmd_ready,
  output logic [apdm_pkg::FRAME_BITS-1:0] rx_data,
  output logic rx_valid,
  output logic ref_wait
);
  import apdm_pkg::*;

  // ******************************
  // sdo synchroniser
  // ******************************
  logic [1:0] sdo_sync;
  logic [1:0] next_sdo_sync;
  always_comb begin
    next_sdo_sync = {sdo_sync[0], link.sdo};
  end
  always_ff @(posedge clk) begin
    if (!rstn) begin
      sdo_sync <= 2'h0;
    end else begin
      sdo_sync <= next_sdo_sync;
    end
  end

  // ******************************
  // sequencer
  // ******************************
  typedef enum logic [2:0] {
    APDM_H_IDLE = 3'b000,
    APDM_H_CSLO = 3'b001,
    APDM_H_CSHI = 3'b010,
    APDM_H_SHIFT = 3'b011,
    APDM_H_WAKE = 3'b100,
    APDM_H_REFW = 3'b101
  } apdm_hst_e;

  apdm_hst_e st;
  apdm_hst_e next_st;
  logic [20:0] tmr;
  logic [20:0] next_tmr;
  logic [2:0] pulses;
  logic [2:0] next_pulses;
  logic [5:0] edges;
  logic [5:0] next_edges;
  logic cs_n;
  logic next_cs_n;
  logic sck;
  logic next_sck;
  logic slept;
  logic next_slept;
  logic [FRAME_BITS-1:0] shreg;
  logic [FRAME_BITS-1:0] next_shreg;
  logic [FRAME_BITS-1:0] next_rx_data;
  logic next_rx_valid;

  // sck held low outside frames and the wake pulse so power-down pulses see it static
  always_comb begin
    next_st = st;
    next_tmr = (tmr != 21'h0) ? tmr - 21'h1 : 21'h0;
    next_pulses = pulses;
    next_edges = edges;
    next_cs_n = cs_n;
    next_sck = sck;
    next_slept = slept;
    next_shreg = shreg;
    next_rx_data = rx_data;
    next_rx_valid = 1'b0;
    case (st)
      APDM_H_IDLE: begin
        if (cmd_valid) begin
          // a phase of n cycles loads n-1: the state acts when the timer reads zero
          next_tmr = 21'(CS_PHASE_CYC - 1);
          case (cmd)
            APDM_CMD_CONV: begin
              next_st = APDM_H_SHIFT;
              next_cs_n = 1'b0;
              next_edges = 6'h0;
              next_tmr = 21'(SCK_HALF_CYC - 1);
            end
            APDM_CMD_NAP: begin
              next_st = APDM_H_CSLO;
              next_cs_n = 1'b0;
              next_pulses = NAP_PULSES;
              next_slept = 1'b0;
            end
            APDM_CMD_SLEEP: begin
              next_st = APDM_H_CSLO;
              next_cs_n = 1'b0;
              next_pulses = SLEEP_PULSES;
              next_slept = 1'b1;
            end
            default: begin
              next_st = APDM_H_WAKE;
              next_sck = 1'b1;
              next_tmr = 21'(SCK_HALF_CYC - 1);
            end
          endcase
        end
      end
      APDM_H_CSLO: begin
        if (tmr == 21'h0) begin
          next_cs_n = 1'b1;
          next_pulses = pulses - 3'h1;
          next_tmr = 21'(CS_PHASE_CYC - 1);
          next_st = APDM_H_CSHI;
        end
      end
      APDM_H_CSHI: begin
        if (tmr == 21'h0) begin
          if (pulses == 3'h0) begin
            next_st = APDM_H_IDLE;
          end else begin
            next_cs_n = 1'b0;
            next_tmr = 21'(CS_PHASE_CYC - 1);
            next_st = APDM_H_CSLO;
          end
        end
      end
      APDM_H_SHIFT: begin
        if (tmr == 21'h0) begin
          next_tmr = 21'(SCK_HALF_CYC - 1);
          if (edges == 6'(2 * FRAME_BITS)) begin
            next_cs_n = 1'b1;
            next_tmr = 21'(CS_PHASE_CYC - 1);
            next_rx_data = shreg;
            next_rx_valid = 1'b1;
            next_st = APDM_H_CSHI;
            next_pulses = 3'h0;
          end else begin
            next_sck = ~sck;
            next_edges = edges + 6'h1;
            // sample just before driving the falling edge
            if (sck) begin
              next_shreg = {shreg[FRAME_BITS-2:0], sdo_sync[1]};
            end
          end
        end
      end
      APDM_H_WAKE: begin
        if (tmr == 21'h0) begin
          next_sck = 1'b0;
          if (slept) begin
            next_tmr = 21'(REF_RECOVER_CYC - 1);
            next_st = APDM_H_REFW;
          end else begin
            next_st = APDM_H_IDLE;
          end
          next_slept = 1'b0;
        end
      end
      APDM_H_REFW: begin
        if (tmr == 21'h0) begin
          next_st = APDM_H_IDLE;
        end
      end
      default: begin
        next_st = APDM_H_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      st <= APDM_H_IDLE;
      tmr <= 21'h0;
      pulses <= 3'h0;
      edges <= 6'h0;
      cs_n <= 1'b1;
      sck <= 1'b0;
      slept <= 1'b0;
      shreg <= '0;
      rx_data <= '0;
      rx_valid <= 1'b0;
    end else begin
      st <= next_st;
      tmr <= next_tmr;
      pulses <= next_pulses;
      edges <= next_edges;
      cs_n <= next_cs_n;
      sck <= next_sck;
      slept <= next_slept;
      shreg <= next_shreg;
      rx_data <= next_rx_data;
      rx_valid <= next_rx_valid;
    end
  end

  assign cmd_ready = (st == APDM_H_IDLE);
  assign ref_wait = (st == APDM_H_REFW);
  assign link.cs_n = cs_n;
  assign link.sck = sck;
endmodule
`default_nettype wire

// ==== core/apdm_pkg.sv ====
package apdm_pkg;
  // ******************************
  // timing
  // ******************************
  localparam int CLK_FREQ_HZ = 125000000;
  localparam int CLK_PERIOD_NS = 8;
  // least reference recovery after sleep wake, in microseconds
  localparam int REF_RECOVER_US = 1100;
  localparam int REF_RECOVER_CYC = (REF_RECOVER_US * (CLK_FREQ_HZ / 1000000));
  // host serial clock divider: half period in clk cycles (64 ns period)
  localparam int SCK_HALF_CYC = 4;
  // host chip select pulse low and high times in clk cycles
  localparam int CS_PHASE_CYC = 8;
  // ******************************
  // frame and power-down counts
  // ******************************
  localparam int FRAME_BITS = 16;
  localparam int DATA_BITS = 14;
  localparam logic [2:0] NAP_PULSES = 3'h2;
  localparam logic [2:0] SLEEP_PULSES = 3'h4;
  // ******************************
  // power state
  // ******************************
  typedef enum logic [1:0] {
    APDM_AWAKE = 2'b00,
    APDM_NAP = 2'b01,
    APDM_SLEEP = 2'b10
  } apdm_pwr_e;
  // ******************************
  // host command
  // ******************************
  typedef enum logic [1:0] {
    APDM_CMD_CONV = 2'b00,
    APDM_CMD_NAP = 2'b01,
    APDM_CMD_SLEEP = 2'b10,
    APDM_CMD_WAKE = 2'b11
  } apdm_cmd_e;
endpackage

// ==== core/apdm_if.sv ====
`timescale 1ns/1ps
`default_nettype none
// ******************************
// serial link between host and converter
// ******************************
interface apdm_if;
  logic cs_n;
  logic sck;
  logic sdo_o;
  logic sdo_oe;
  // released sdo reads high, so a host sampling too early misses the leading zeros
  wire sdo = sdo_oe ? sdo_o : 1'b1;
  modport device (input cs_n, input sck, output sdo_o, output sdo_oe);
  modport host (output cs_n, output sck, input sdo);
endinterface
`default_nettype wire

// ==== core/apdm_device.sv ====
`timescale 1ns/1ps
`default_nettype none
module apdm_device (
  input wire logic clk,
  input wire logic rstn,
  apdm_if.device link,
  input wire logic [apdm_pkg::DATA_BITS-1:0] sample,
  output logic [apdm_pkg::DATA_BITS-1:0] result,
  output logic result_valid,
  output logic bias_en,
  output logic ref_en,
  output apdm_pkg::apdm_pwr_e pwr_state
);
  import apdm_pkg::*;

  // ******************************
  // pin synchronisers
  // ******************************
  logic [1:0] cs_sync;
  logic [1:0] sck_sync;
  logic [1:0] next_cs_sync;
  logic [1:0] next_sck_sync;
  logic cs_q;
  logic sck_q;
  logic next_cs_q;
  logic next_sck_q;

  // first stage feeds only the second
  always_comb begin
    next_cs_sync = {cs_sync[0], link.cs_n};
    next_sck_sync = {sck_sync[0], link.sck};
    next_cs_q = cs_sync[1];
    next_sck_q = sck_sync[1];
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      cs_sync <= 2'h3;
      sck_sync <= 2'h0;
      cs_q <= 1'b1;
      sck_q <= 1'b0;
    end else begin
      cs_sync <= next_cs_sync;
      sck_sync <= next_sck_sync;
      cs_q <= next_cs_q;
      sck_q <= next_sck_q;
    end
  end

  logic cs_fall;
  logic cs_rise;
  logic sck_fall;
  logic sck_edge;
  assign cs_fall = cs_q & ~cs_sync[1];
  assign cs_rise = ~cs_q & cs_sync[1];
  assign sck_fall = sck_q & ~sck_sync[1];
  assign sck_edge = sck_q ^ sck_sync[1];

  // ******************************
  // power state and pulse counting
  // ******************************
  apdm_pwr_e pwr;
  apdm_pwr_e next_pwr;
  logic [2:0] pulse_cnt;
  logic [2:0] next_pulse_cnt;
  logic sck_moved;
  logic next_sck_moved;
  logic clean_rise;
  logic [2:0] cnt_inc;

  // a pulse counts only if sck stayed still from its fall to its rise
  assign clean_rise = cs_rise & ~sck_edge & ~sck_moved;
  assign cnt_inc = pulse_cnt + 3'h1;

  // any clock edge restarts counting so a real frame never powers down
  // limitation: a sleep request passes through nap after its second pulse
  always_comb begin
    next_pwr = pwr;
    next_pulse_cnt = pulse_cnt;
    next_sck_moved = sck_moved;
    if (sck_edge) begin
      next_pulse_cnt = 3'h0;
      next_sck_moved = 1'b1;
    end else if (cs_fall) begin
      next_sck_moved = 1'b0;
    end else if (cs_rise) begin
      if (sck_moved) begin
        next_pulse_cnt = 3'h0;
      end else if (pulse_cnt != 3'h7) begin
        next_pulse_cnt = cnt_inc;
      end
    end
    case (pwr)
      APDM_AWAKE: begin
        if (clean_rise && cnt_inc == NAP_PULSES) begin
          next_pwr = APDM_NAP;
        end
      end
      APDM_NAP: begin
        // a full clock pulse wakes, taken on its falling edge
        if (sck_fall) begin
          next_pwr = APDM_AWAKE;
        end else if (clean_rise && cnt_inc == SLEEP_PULSES) begin
          next_pwr = APDM_SLEEP;
        end
      end
      APDM_SLEEP: begin
        if (sck_fall) begin
          next_pwr = APDM_AWAKE;
        end
      end
      default: begin
        next_pwr = APDM_AWAKE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      pwr <= APDM_AWAKE;
      pulse_cnt <= 3'h0;
      sck_moved <= 1'b0;
    end else begin
      pwr <= next_pwr;
      pulse_cnt <= next_pulse_cnt;
      sck_moved <= next_sck_moved;
    end
  end

  // bias stays up in nap so wake-up converts at once
  always_comb begin
    bias_en = (pwr != APDM_SLEEP);
    ref_en = (pwr != APDM_SLEEP);
    pwr_state = pwr;
  end

  // ******************************
  // conversion frame and data output
  // ******************************
  logic in_frame;
  logic next_in_frame;
  logic [4:0] fall_cnt;
  logic [4:0] next_fall_cnt;
  logic [FRAME_BITS-1:0] shreg;
  logic [FRAME_BITS-1:0] next_shreg;
  logic [DATA_BITS-1:0] held;
  logic [DATA_BITS-1:0] next_held;
  logic sdo_oe_r;
  logic next_sdo_oe_r;
  logic [DATA_BITS-1:0] next_result;
  logic next_result_valid;

  // one cycle of latency: a frame shifts out the previous sample
  always_comb begin
    next_in_frame = in_frame;
    next_fall_cnt = fall_cnt;
    next_shreg = shreg;
    next_held = held;
    next_sdo_oe_r = sdo_oe_r;
    next_result = result;
    next_result_valid = 1'b0;
    if (cs_rise) begin
      next_in_frame = 1'b0;
      next_sdo_oe_r = 1'b0;
      if (fall_cnt >= 5'(FRAME_BITS)) begin
        next_result = sample;
        next_result_valid = 1'b1;
      end
    end else if (cs_fall && pwr == APDM_AWAKE) begin
      next_in_frame = 1'b1;
      next_fall_cnt = 5'h0;
      next_sdo_oe_r = 1'b1;
      next_shreg = {2'b00, held};
      next_held = sample;
    end else if (in_frame && sck_fall) begin
      next_shreg = {shreg[FRAME_BITS-2:0], 1'b0};
      if (fall_cnt != 5'h1F) begin
        next_fall_cnt = fall_cnt + 5'h1;
      end
      if (fall_cnt == 5'(FRAME_BITS - 1)) begin
        next_sdo_oe_r = 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      in_frame <= 1'b0;
      fall_cnt <= 5'h0;
      shreg <= '0;
      held <= '0;
      sdo_oe_r <= 1'b0;
      result <= '0;
      result_valid <= 1'b0;
    end else begin
      in_frame <= next_in_frame;
      fall_cnt <= next_fall_cnt;
      shreg <= next_shreg;
      held <= next_held;
      sdo_oe_r <= next_sdo_oe_r;
      result <= next_result;
      result_valid <= next_result_valid;
    end
  end

  assign link.sdo_o = shreg[FRAME_BITS-1];
  assign link.sdo_oe = sdo_oe_r;
endmodule
`default_nettype wire

// ==== tb/apdm_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
// ****
// link checks
// ****
module apdm_chk (
  input wire logic clk,
  input wire logic rstn,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic sdo_o,
  input wire logic sdo_oe
);
  logic cs_q;
  logic sck_q;
  logic [5:0] falls;
  logic [5:0] next_falls;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  // falling sck edges in the frame, cleared by a chip select fall
  always_comb begin
    next_falls = falls;
    if (cs_q && !cs_n) begin
      next_falls = 6'h00;
    end else if (!cs_n && sck_q && !sck && falls != 6'h3F) begin
      next_falls = falls + 6'h01;
    end
  end
  // edge history; saturates so long bursts cannot wrap
  always_ff @(posedge clk) begin
    cs_q <= cs_n;
    sck_q <= sck;
    falls <= rstn ? next_falls : 6'h00;
  end
  sequence s_last;
    !cs_n && falls == 6'h10;
  endsequence
  sequence s_float;
    ##[0:6] !sdo_oe;
  endsequence
  property p_oe_idle;
    cs_n [*8] |-> !sdo_oe;
  endproperty
  property p_oe_cs;
    $rose(sdo_oe) |-> !cs_n;
  endproperty
  property p_sck_half;
    $rose(sck) |-> sck [*4] ##1 !sck;
  endproperty
  property p_cs_setup;
    $fell(cs_n) |-> !sck [*4];
  endproperty
  property p_float;
    s_last |-> s_float;
  endproperty
  property p_frame;
    $rose(cs_n) && falls != 6'h00 |-> ##[0:1] falls == 6'h10;
  endproperty
  property p_zeros;
    !cs_n && sdo_oe && falls < 6'h02 |-> !sdo_o;
  endproperty
  property p_sdo_low;
    sdo_oe && $past(sdo_oe) && !$stable(sdo_o) |-> !sck;
  endproperty
  a_oe_idle: assert property (p_oe_idle) else $error("sdo driven while deselected");
  a_oe_cs: assert property (p_oe_cs) else $error("sdo enabled without select");
  a_sck_half: assert property (p_sck_half) else $error("sck pulse width wrong");
  a_cs_setup: assert property (p_cs_setup) else $error("sck too soon after select");
  a_float: assert property (p_float) else $error("sdo not floated after last edge");
  a_frame: assert property (p_frame) else $error("frame cut short");
  a_zeros: assert property (p_zeros) else $error("leading bit not zero");
  a_sdo_low: assert property (p_sdo_low) else $error("sdo moved while sck high");
endmodule
`default_nettype wire

// ==== tb/adc_power_down_mode_control_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module adc_power_down_mode_control_tb;
  import apdm_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [DATA_BITS-1:0] sample = '0;
  logic [DATA_BITS-1:0] prev;
  logic [DATA_BITS-1:0] result;
  logic cmd_valid = 1'b0;
  apdm_cmd_e cmd = APDM_CMD_CONV;
  logic result_valid;
  logic bias_en;
  logic ref_en;
  logic cmd_ready;
  logic rx_valid;
  logic ref_wait;
  apdm_pwr_e pwr_state;
  logic [FRAME_BITS-1:0] rx_data;
  int fails = 0;
  int check_count = 0;
  int convs = 0;
  int valid_seen = 0;
  apdm_if link ();
  apdm_device apdm_device_i (.clk(clk), .rstn(rstn), .link(link), .sample(sample),
    .result(result), .result_valid(result_valid), .bias_en(bias_en), .ref_en(ref_en),
    .pwr_state(pwr_state));
  apdm_host apdm_host_i (.clk(clk), .rstn(rstn), .link(link), .cmd_valid(cmd_valid),
    .cmd(cmd), .cmd_ready(cmd_ready), .rx_data(rx_data), .rx_valid(rx_valid),
    .ref_wait(ref_wait));
  apdm_chk apdm_chk_i (.clk(clk), .rstn(rstn), .cs_n(link.cs_n), .sck(link.sck),
    .sdo_o(link.sdo_o), .sdo_oe(link.sdo_oe));
  // result pulses, one per completed frame
  always @(posedge clk) begin
    if (result_valid === 1'b1) begin
      valid_seen++;
    end
  end
  // ****
  // helpers
  // ****
  task automatic finish_test();
    if (fails == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk_val(string what, logic [15:0] exp, logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_bit(string what, logic exp, logic got);
    chk_val(what, {15'h0000, exp}, {15'h0000, got});
  endtask
  // edge reads see pre-edge values, as the design does
  task automatic wait_on(int which, int lim);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while ((which == 0 ? cmd_ready : rx_valid) !== 1'b1 && n < lim);
    if (n >= lim) begin
      fails++;
      $display("[FAIL] handshake expected 1 seen 0");
    end
  endtask
  task automatic send(apdm_cmd_e c);
    wait_on(0, 4000);
    cmd <= c;
    cmd_valid <= 1'b1;
    @(posedge clk);
    cmd_valid <= 1'b0;
  endtask
  // one frame; data lags one conversion behind
  task automatic conv(logic chk);
    send(APDM_CMD_CONV);
    wait_on(1, 400);
    if (chk) begin
      chk_val("rx_data", {2'b00, prev}, rx_data);
    end
    wait_on(0, 400);
    chk_val("result", {2'b00, sample}, {2'b00, result});
    prev = sample;
    convs++;
  endtask
  // ****
  // clock, watchdog, sequence
  // ****
  initial begin
    forever begin
      #(CLK_PERIOD_NS / 2);
      clk = ~clk;
    end
  end
  // run needs a few thousand cycles
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    $display("[FAIL] watchdog expected done seen hang");
    finish_test();
  end
  initial begin
    void'($urandom(32'hB4D59E33));
    prev = '0;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    conv(1'b0);
    // full scale and zero first, then random codes
    for (int i = 0; i < 8; i++) begin
      sample <= (i == 0) ? 14'h3FFF : (i == 1) ? 14'h0000 : DATA_BITS'($urandom);
      conv(1'b1);
    end
    // frames move sck, so their chip select rises never add up to a nap
    chk_val("pwr_state", 16'(APDM_AWAKE), 16'(pwr_state));
    send(APDM_CMD_NAP);
    wait_on(0, 400);
    chk_val("pwr_state", 16'(APDM_NAP), 16'(pwr_state));
    chk_bit("bias_en", 1'b1, bias_en);
    chk_bit("ref_en", 1'b1, ref_en);
    send(APDM_CMD_WAKE);
    wait_on(0, 400);
    // the device sees the sck fall through its synchroniser
    repeat (4) @(posedge clk);
    chk_bit("ref_wait", 1'b0, ref_wait);
    chk_val("pwr_state", 16'(APDM_AWAKE), 16'(pwr_state));
    sample <= DATA_BITS'($urandom);
    conv(1'b1);
    send(APDM_CMD_SLEEP);
    wait_on(0, 400);
    chk_val("pwr_state", 16'(APDM_SLEEP), 16'(pwr_state));
    chk_bit("bias_en", 1'b0, bias_en);
    chk_bit("ref_en", 1'b0, ref_en);
    send(APDM_CMD_WAKE);
    // recovery is far longer than this run, so only its start is seen
    repeat (40) @(posedge clk);
    chk_bit("ref_wait", 1'b1, ref_wait);
    chk_bit("cmd_ready", 1'b0, cmd_ready);
    chk_bit("bias_en", 1'b1, bias_en);
    chk_val("pwr_state", 16'(APDM_AWAKE), 16'(pwr_state));
    repeat (1000) @(posedge clk);
    chk_bit("ref_wait", 1'b1, ref_wait);
    chk_val("result_valid", 16'(convs), 16'(valid_seen));
    finish_test();
  end
endmodule
`default_nettype wire
